/* File: logic/lst_top.sv */
// Purpose: Loop signal timing for a station port and a trunk channel
// Assumes: Inputs synchronous to aclk, software sets sane ranges
// Notes: All intervals have one millisecond resolution
module lst_top #(
   parameter int unsigned TICK_DIV = lst_pkg::TICK_CYC // Cycles per ms
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic st_loop_closed,   // Station loop current seen
   input wire logic far_disc,         // Far end released, pulse
   input wire logic [7:0] ring_req,   // Ports that want ringing
   input wire logic tr_loop_current,  // Trunk loop current seen
   input wire logic tr_rx_closed,     // Trunk receive make state
   output logic st_loop_open,         // Open the station loop
   output logic [7:0] ring_out,       // Ring drive per port
   output logic tr_seize,             // Trunk line seized
   output logic tr_tx_closed,         // Trunk transmit relay closed
   output logic irq                   // Unmasked status pending
);
   import lst_pkg::*;

   ////////////////////////////////////////////////////////////////
   // State record

   localparam logic [14:0] DIV_LAST = 15'(TICK_DIV - 1);

   typedef struct packed {
      logic aw_h;                // Write address held
      logic [7:0] aw_a;
      logic w_h;                 // Write data held
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
      logic [7:0] ctrl;          // Loop open enable, last digit
      logic [7:0] stat;          // Sticky events
      logic [7:0] mask;          // Interrupt enables
      logic [CFG_N-1:0][31:0] cfg;
      logic [14:0] div;          // Tick divider
      logic tick;                // One ms pulse
      lst_st_type st;
      logic [15:0] st_ms;        // Time since station change
      logic [15:0] dpg;          // Pulse guard left
      logic [3:0] st_pc;         // Station breaks counted
      logic [3:0] st_dig;
      logic offh;
      logic [15:0] ld;           // Loop open time left
      logic lopen;
      logic [1:0] rg;            // Ringing group
      logic [15:0] rg_ms;
      logic [7:0] ring;
      logic [15:0] sz_ms;        // Steady loop current time
      logic seized;
      logic tr_lvl;              // Last trunk receive state
      logic [15:0] tr_ms;
      logic [3:0] tr_pc;
      logic [3:0] tr_dig;
      lst_tx_type tx;
      logic [15:0] tx_ms;
      logic [3:0] tx_left;       // Breaks still to send
      logic tx_cl;
   } lst_state_type;

   lst_state_type s;             // Registered state
   lst_state_type n;             // Next state

   ////////////////////////////////////////////////////////////////
   // Helpers

   // Saturating ms count, so a long wait never wraps
   function automatic logic [15:0] inc(input logic [15:0] v);
      inc = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : inc

   // Inclusive window test
   function automatic logic inr(input logic [15:0] v, input logic [15:0] lo,
                                input logic [15:0] hi);
      inr = (v >= lo) && (v <= hi);
   endfunction : inr

   // Setting lookup, h selects the upper half
   function automatic logic [15:0] cf(input int i, input logic h);
      cf = h ? s.cfg[i][31:16] : s.cfg[i][15:0];
   endfunction : cf

   // Byte lane merge for strobed writes
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] be);
      merge = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[8*i +: 8] = d[8*i +: 8];
         end
      end
   endfunction : merge

   // Settings window decode
   function automatic logic cfg_hit(input logic [7:0] a);
      cfg_hit = (a >= A_CFG) && (a < A_CFG + 8'(4 * CFG_N)) && (a[1:0] == 2'h0);
   endfunction : cfg_hit

   function automatic logic [3:0] cfg_idx(input logic [7:0] a);
      cfg_idx = 4'((a - A_CFG) >> 2);
   endfunction : cfg_idx

   // Break count to digit value
   function automatic logic [3:0] digit(input logic [3:0] c);
      digit = (c == 4'hA) ? 4'h0 : c;
   endfunction : digit

   // Register read, top bit flags a mapped address
   function automatic logic [32:0] rd_val(input logic [7:0] a);
      rd_val = {1'b1, 32'h0};
      if (a == A_CTRL) begin
         rd_val[7:0] = s.ctrl;
      end else if (a == A_STAT) begin
         rd_val[7:0] = s.stat;
      end else if (a == A_MASK) begin
         rd_val[7:0] = s.mask;
      end else if (a == A_INFO) begin
         rd_val[11:0] = {s.tx != TX_IDLE, s.seized, s.lopen, s.offh,
                         s.tr_dig, s.st_dig};
      end else if (cfg_hit(a)) begin
         rd_val[31:0] = s.cfg[cfg_idx(a)];
      end else begin
         rd_val = '0;
      end
   endfunction : rd_val

   ////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [7:0] ev;            // Events raised this cycle
      logic [7:0] clr;           // Status bits software clears
      logic go;                  // Transmit start write
      logic [32:0] rx;           // Read lookup
      logic [31:0] wv;           // Merged write value
      ev = '0;
      clr = '0;
      go = 1'b0;
      rx = '0;
      wv = '0;
      n = s;

      // Common ms tick drives every timer
      n.tick = 1'b0;
      if (s.div == DIV_LAST) begin
         n.div = '0;
         n.tick = 1'b1;
      end else begin
         n.div = s.div + 15'h0001;
      end

      // Write address and data taken in either order
      if (s_axi_awvalid && !s.aw_h) begin
         n.aw_h = 1'b1;
         n.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_h) begin
         n.w_h = 1'b1;
         n.w_d = s_axi_wdata;
         n.w_s = s_axi_wstrb;
      end
      if (s.bv && s_axi_bready) begin
         n.bv = 1'b0;
      end
      // Both halves present, no answer pending
      if (s.aw_h && s.w_h && !s.bv) begin
         rx = rd_val(s.aw_a);
         wv = merge(rx[31:0], s.w_d, s.w_s);
         n.aw_h = 1'b0;
         n.w_h = 1'b0;
         n.bv = 1'b1;
         n.br = rx[32] ? R_OK : R_SLV;
         if (s.aw_a == A_CTRL) begin
            // Start bit is a strobe, never stored
            n.ctrl = wv[7:0] & 8'hF1;
            go = s.w_s[0] && s.w_d[F_GO] && (s.w_d[F_DIG +: 4] <= 4'hA);
         end else if (s.aw_a == A_STAT) begin
            clr = s.w_s[0] ? s.w_d[7:0] : 8'h00;
         end else if (s.aw_a == A_MASK) begin
            n.mask = wv[7:0];
         end else if (cfg_hit(s.aw_a)) begin
            n.cfg[cfg_idx(s.aw_a)] = wv;
         end
      end

      // Read answered one cycle after address taken
      if (s.rv && s_axi_rready) begin
         n.rv = 1'b0;
      end
      if (s_axi_arvalid && !s.rv) begin
         rx = rd_val(s_axi_araddr);
         n.rv = 1'b1;
         n.rd = rx[31:0];
         n.rr = rx[32] ? R_OK : R_SLV;
      end

      // Station hook and dial pulse decoder
      if (s.tick) begin
         n.st_ms = inc(s.st_ms);
      end
      if (s.tick && (s.dpg != 16'h0000)) begin
         n.dpg = s.dpg - 16'h0001;
      end
      case (s.st)
         ST_IDLE: begin
            if (st_loop_closed) begin
               n.st = ST_QUAL;
               n.st_ms = '0;
            end
         end
         ST_QUAL: begin
            // Must stay off-hook without a gap
            if (!st_loop_closed) begin
               n.st = ST_IDLE;
               n.st_ms = '0;
            end else if (s.st_ms >= cf(C_OFFH, 1'b0)) begin
               n.st = ST_OFF;
               n.st_ms = '0;
               n.offh = 1'b1;
               n.dpg = '0;
               n.st_pc = '0;
               ev[S_OFFH] = 1'b1;
            end
         end
         ST_OFF: begin
            if (!st_loop_closed) begin
               n.st = ST_OPEN;
               n.st_ms = '0;
               // Make between two breaks of one digit
               if ((s.st_pc != 4'h0) &&
                   !inr(s.st_ms, cf(C_ST_MK, 1'b0), cf(C_ST_MK, 1'b1))) begin
                  n.st_pc = '0;
                  ev[S_ERR] = 1'b1;
               end
            end else if ((s.st_pc != 4'h0) && (s.st_ms > cf(C_ST_MK, 1'b1))) begin
               // Long make closes the digit
               n.st_dig = digit(s.st_pc);
               n.st_pc = '0;
               n.dpg = cf(C_OFFH, 1'b1);
               ev[S_STDIG] = 1'b1;
            end
         end
         ST_OPEN: begin
            if (st_loop_closed) begin
               n.st = ST_OFF;
               n.st_ms = '0;
               if (inr(s.st_ms, cf(C_ST_BRK, 1'b0), cf(C_ST_BRK, 1'b1))) begin
                  // Breaks during the guard are dropped
                  if (s.dpg == 16'h0000) begin
                     n.st_pc = (s.st_pc == 4'hA) ? s.st_pc : s.st_pc + 4'h1;
                  end
               end else if (s.st_ms > cf(C_FLASH, 1'b0)) begin
                  n.st_pc = '0;
                  ev[S_FLASH] = 1'b1;
               end
            end else if (s.st_ms > cf(C_FLASH, 1'b1)) begin
               n.st = ST_GUARD;
               n.st_ms = '0;
               n.offh = 1'b0;
               n.st_pc = '0;
               ev[S_HANG] = 1'b1;
            end
         end
         ST_GUARD: begin
            // Line ignored while it settles
            if (s.st_ms >= cf(C_GUARD, 1'b0)) begin
               n.st = ST_IDLE;
               n.st_ms = '0;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // Loop open after far end release
      if (s.tick && (s.ld != 16'h0000)) begin
         n.ld = s.ld - 16'h0001;
      end
      if (far_disc && s.ctrl[F_LDEN]) begin
         n.ld = cf(C_GUARD, 1'b1);
      end
      n.lopen = n.ld != 16'h0000;

      // Ring rotation limits supply load
      if (s.tick) begin
         n.rg_ms = inc(s.rg_ms);
      end
      if (s.rg_ms >= cf(C_RING, 1'b0)) begin
         n.rg = s.rg + 2'h1;
         n.rg_ms = '0;
      end
      n.ring = ring_req & 8'(8'h03 << {s.rg, 1'b0});

      // Trunk seize on steady loop current
      if (!tr_loop_current) begin
         n.sz_ms = '0;
         n.seized = 1'b0;
      end else begin
         if (s.tick) begin
            n.sz_ms = inc(s.sz_ms);
         end
         if (!s.seized && (s.sz_ms >= cf(C_RING, 1'b1))) begin
            n.seized = 1'b1;
            ev[S_SEIZE] = 1'b1;
         end
      end

      // Trunk receive pulse checker
      if (s.tick) begin
         n.tr_ms = inc(s.tr_ms);
      end
      if (tr_rx_closed != s.tr_lvl) begin
         n.tr_lvl = tr_rx_closed;
         n.tr_ms = '0;
         if (tr_rx_closed) begin
            if (inr(s.tr_ms, cf(C_TR_BRK, 1'b0), cf(C_TR_BRK, 1'b1))) begin
               n.tr_pc = (s.tr_pc == 4'hA) ? s.tr_pc : s.tr_pc + 4'h1;
            end else if (s.tr_pc != 4'h0) begin
               n.tr_pc = '0;
               ev[S_ERR] = 1'b1;
            end
         end else if ((s.tr_pc != 4'h0) &&
                      !inr(s.tr_ms, cf(C_TR_MK, 1'b0), cf(C_TR_MK, 1'b1))) begin
            n.tr_pc = '0;
            ev[S_ERR] = 1'b1;
         end
      end else if (s.tr_lvl && (s.tr_pc != 4'h0) && (s.tr_ms > cf(C_TR_MK, 1'b1))) begin
         n.tr_dig = digit(s.tr_pc);
         n.tr_pc = '0;
         ev[S_TRDIG] = 1'b1;
      end

      // Transmit pulse generator
      if (s.tick && (s.tx != TX_IDLE)) begin
         n.tx_ms = inc(s.tx_ms);
      end
      case (s.tx)
         TX_IDLE: begin
            // Start refused while a digit is out
            if (go) begin
               n.tx = TX_BRK;
               n.tx_ms = '0;
               n.tx_cl = 1'b0;
               n.tx_left = (s.w_d[F_DIG +: 4] == 4'h0) ? 4'hA : s.w_d[F_DIG +: 4];
            end
         end
         TX_BRK: begin
            if (s.tx_ms >= cf(C_TX, 1'b0)) begin
               n.tx = TX_MAKE;
               n.tx_ms = '0;
               n.tx_cl = 1'b1;
               n.tx_left = s.tx_left - 4'h1;
            end
         end
         TX_MAKE: begin
            if (s.tx_ms >= cf(C_TX, 1'b1)) begin
               n.tx_ms = '0;
               if (s.tx_left != 4'h0) begin
                  n.tx = TX_BRK;
                  n.tx_cl = 1'b0;
               end else begin
                  n.tx = TX_IDG;
               end
            end
         end
         TX_IDG: begin
            // Line rests closed until next digit
            if (s.tx_ms >= cf(C_TX_IDG, 1'b0)) begin
               n.tx = TX_IDLE;
               ev[S_TXDONE] = 1'b1;
            end
         end
         default: begin
            n.tx = TX_IDLE;
         end
      endcase

      // Set wins over a clear in the same cycle
      n.stat = (s.stat & ~clr) | ev;

      // Synchronous reset values
      if (!aresetn) begin
         n = '0;
         n.cfg = CFG_RST;
         n.tr_lvl = 1'b1;
         n.tx_cl = 1'b1;
         n.st = ST_IDLE;
         n.tx = TX_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge aclk) begin
      s <= n;
   end

   ////////////////////////////////////////////////////////////////
   // Outputs

   assign s_axi_awready = !s.aw_h;
   assign s_axi_wready = !s.w_h;
   assign s_axi_bvalid = s.bv;
   assign s_axi_bresp = s.br;
   assign s_axi_arready = !s.rv;
   assign s_axi_rvalid = s.rv;
   assign s_axi_rdata = s.rd;
   assign s_axi_rresp = s.rr;
   assign st_loop_open = s.lopen;
   assign ring_out = s.ring;
   assign tr_seize = s.seized;
   assign tr_tx_closed = s.tx_cl;
   assign irq = |(s.stat & s.mask);
endmodule : lst_top

/* File: logic/lst_pkg.sv */
// Purpose: Shared constants for the loop signal timing block
// Assumes: 20 MHz clock, AXI4-Lite register access
// Notes: Every timer setting is a count of milliseconds
package lst_pkg;
   // Clock and millisecond tick
   localparam int unsigned CLK_NS = 50;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned TICK_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_MASK = 8'h08;
   localparam logic [7:0] A_INFO = 8'h0C;
   localparam logic [7:0] A_CFG = 8'h10;
   localparam int CFG_N = 10;
   // Setting words: low half, high half
   localparam int C_ST_BRK = 0;   // Station break min, max
   localparam int C_ST_MK = 1;    // Station make min, max
   localparam int C_FLASH = 2;    // Hookflash min, max
   localparam int C_OFFH = 3;     // Off-hook min, pulse guard
   localparam int C_GUARD = 4;    // Hang-up guard, loop open
   localparam int C_RING = 5;     // Ring slot, trunk seize
   localparam int C_TR_BRK = 6;   // Trunk break min, max
   localparam int C_TR_MK = 7;    // Trunk make min, max
   localparam int C_TX = 8;       // Transmit break, make
   localparam int C_TX_IDG = 9;   // Transmit interdigit
   // Control fields
   localparam int F_LDEN = 0;
   localparam int F_GO = 1;
   localparam int F_DIG = 4;
   // Status and mask bits
   localparam int S_STDIG = 0;
   localparam int S_FLASH = 1;
   localparam int S_HANG = 2;
   localparam int S_OFFH = 3;
   localparam int S_ERR = 4;
   localparam int S_SEIZE = 5;
   localparam int S_TRDIG = 6;
   localparam int S_TXDONE = 7;
   // Bus answers
   localparam logic [1:0] R_OK = 2'h0;
   localparam logic [1:0] R_SLV = 2'h2;
   // Default settings in ms
   localparam logic [15:0] D_BRK_MIN = 16'h000A;
   localparam logic [15:0] D_BRK_MAX = 16'h0064;
   localparam logic [15:0] D_MK_MIN = 16'h000A;
   localparam logic [15:0] D_MK_MAX = 16'h0064;
   localparam logic [15:0] D_FL_MIN = 16'h0069;
   localparam logic [15:0] D_FL_MAX = 16'h03E8;
   localparam logic [15:0] D_OFFH = 16'h0069;
   localparam logic [15:0] D_DPG = 16'h015E;
   localparam logic [15:0] D_HKG = 16'h012C;
   localparam logic [15:0] D_LD = 16'h07D0;
   localparam logic [15:0] D_RING = 16'h02EE;
   localparam logic [15:0] D_SZ = 16'h0030;
   localparam logic [15:0] D_TBRK_MIN = 16'h0014;
   localparam logic [15:0] D_TBRK_MAX = 16'h0068;
   localparam logic [15:0] D_TMK_MIN = 16'h000C;
   localparam logic [15:0] D_TMK_MAX = 16'h004C;
   localparam logic [15:0] D_TXB = 16'h003C;
   localparam logic [15:0] D_TXM = 16'h0028;
   localparam logic [15:0] D_IDG = 16'h0320;
   localparam logic [CFG_N-1:0][31:0] CFG_RST = {
      {16'h0000, D_IDG}, {D_TXM, D_TXB}, {D_TMK_MAX, D_TMK_MIN},
      {D_TBRK_MAX, D_TBRK_MIN}, {D_SZ, D_RING}, {D_LD, D_HKG},
      {D_DPG, D_OFFH}, {D_FL_MAX, D_FL_MIN}, {D_MK_MAX, D_MK_MIN},
      {D_BRK_MAX, D_BRK_MIN}};
   // Station and transmit sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_QUAL, ST_OFF, ST_OPEN, ST_GUARD} lst_st_type;
   typedef enum logic [1:0] {TX_IDLE, TX_BRK, TX_MAKE, TX_IDG} lst_tx_type;
endpackage : lst_pkg

/* File: tb/lst_properties.sv */
// Purpose: Port timing checks for the loop signal timing block
// Assumes: Default transmit break and seize settings
// Notes: Bound from the bench top file
module lst_properties #(
   parameter int unsigned TICK_DIV = 20, // Cycles per ms
   parameter int TXB_MS = 60, // Transmit break ms
   parameter int SZ_MS = 48 // Seize qualify ms
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic far_disc,
   input wire logic [7:0] ring_req,
   input wire logic tr_loop_current,
   input wire logic st_loop_open,
   input wire logic [7:0] ring_out,
   input wire logic tr_seize,
   input wire logic tr_tx_closed
);
   timeunit 1ns;
   timeprecision 1ns;
   int lo_cnt; // Cycles relay held open
   int cur_cnt; // Cycles of steady loop current
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // Run lengths, cleared on each change so a stuck timer shows up
   always_ff @(posedge aclk) begin
      lo_cnt <= (!aresetn || tr_tx_closed) ? 0 : lo_cnt + 1;
      cur_cnt <= (!aresetn || !tr_loop_current) ? 0 : cur_cnt + 1;
   end
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_r_waiting;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   AST_AR_ANSWER: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   AST_R_HOLD: assert property (s_r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   AST_RING_ONE: assert property ($onehot0({|ring_out[7:6], |ring_out[5:4],
      |ring_out[3:2], |ring_out[1:0]}))
      else $error("two ring groups active");
   AST_RING_REQ: assert property ((ring_out & ~$past(ring_req)) == 8'h00)
      else $error("ring without request");
   AST_SEIZE_DROP: assert property (!tr_loop_current |=> !tr_seize)
      else $error("seize held without current");
   AST_SEIZE_WAIT: assert property ($rose(tr_seize) |-> cur_cnt >= (SZ_MS - 1) * TICK_DIV)
      else $error("seize too early");
   AST_TX_BREAK: assert property ($rose(tr_tx_closed) |->
      lo_cnt >= (TXB_MS - 1) * TICK_DIV && lo_cnt <= TXB_MS * TICK_DIV + 2)
      else $error("transmit break length wrong");
   AST_LOOP_OPEN: assert property ($rose(st_loop_open) |-> $past(far_disc))
      else $error("loop opened without far release");
endmodule : lst_properties

/* File: tb/lst_line_model.sv */
// Purpose: Telephone set and trunk provider seen from the block
// Assumes: TD cycles make one ms
// Notes: Pulses at ten per second, station half break half make, trunk 60 ms break 40 ms make
module lst_line_model #(
   parameter int TD = 20 // Cycles per ms
) (
   input wire logic aclk,
   output logic st_loop_closed,
   output logic far_disc,
   output logic [7:0] ring_req,
   output logic tr_loop_current,
   output logic tr_rx_closed
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle line: on-hook set, trunk at rest in make
   initial begin
      st_loop_closed = 1'b0;
      far_disc = 1'b0;
      ring_req = 8'h00;
      tr_loop_current = 1'b0;
      tr_rx_closed = 1'b1;
   end
   task automatic ms(input int n);
      repeat (n * TD) @(posedge aclk);
   endtask : ms
   task automatic st(input logic v, input int n);
      st_loop_closed <= v;
      ms(n);
   endtask : st
   // Ten pulses a second keeps within default limits
   task automatic st_digit(input int n);
      repeat (n) begin
         st(1'b0, 50);
         st(1'b1, 50);
      end
   endtask : st_digit
   task automatic tr_digit(input int n);
      repeat (n) begin
         tr_rx_closed <= 1'b0;
         ms(60);
         tr_rx_closed <= 1'b1;
         ms(40);
      end
   endtask : tr_digit
   task automatic far_pulse();
      far_disc <= 1'b1;
      @(posedge aclk);
      far_disc <= 1'b0;
   endtask : far_pulse
   task automatic cur(input logic v);
      tr_loop_current <= v;
   endtask : cur
   task automatic ring(input logic [7:0] v);
      ring_req <= v;
   endtask : ring
endmodule : lst_line_model

/* File: tb/lst_top_tb_top.sv */
// Purpose: Self-checking bench for the loop signal timing block
// Assumes: One ms shortened to 20 cycles
// Notes: Timeout counts as a mismatch
module lst_top_tb_top import lst_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TD = 20; // Cycles per ms
   localparam int LIMIT = 95000; // Cycle ceiling
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, irq, far_disc, st_loop_open, st_loop_closed;
   logic tr_loop_current, tr_rx_closed, tr_seize, tr_tx_closed;
   logic [7:0] s_axi_awaddr, s_axi_araddr, ring_req, ring_out;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, b_last;
   int failures, n_tests, cyc;
   lst_top #(.TICK_DIV(TD)) u_lst_top (.*);
   lst_line_model #(.TD(TD)) u_lst_line_model (.*);
   always #25 aclk = ~aclk;
   ////////////////////////////////////////
   // Bus helpers; each ends one edge past its last change
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= be;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      b_last = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Read a register and compare the masked field
   task automatic rdf(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d & m, e);
   endtask : rdf
   task automatic summarize();
      $display("checks=%0d failures=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   ////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < CFG_N; i++) rdf(A_CFG + 8'(4 * i), 32'hFFFFFFFF, CFG_RST[i]);
      rdf(A_CTRL, 32'hFFFFFFFF, 32'h0);
      rd(8'h40, d, r); // Unmapped place
      chk(d, 32'h0);
      chk(32'(r), 32'(R_SLV));
      wr(8'h40, 32'h1);
      chk(32'(b_last), 32'(R_SLV));
      wr(A_CFG, 32'hFFFFFF05, 4'h1);
      rdf(A_CFG, 32'hFFFFFFFF, {D_BRK_MAX, D_BRK_MIN[15:8], 8'h05});
      $display("regs done");
   endtask : t_regs
   task automatic t_station();
      u_lst_line_model.st(1'b1, 100);
      rdf(A_INFO, 32'h100, 32'h0);
      u_lst_line_model.ms(10);
      rdf(A_INFO, 32'h100, 32'h100);
      wr(A_MASK, 32'h0);
      chk(32'(irq), 32'h0);
      wr(A_MASK, 32'h08);
      chk(32'(irq), 32'h1);
      wr(A_STAT, 32'h08);
      chk(32'(irq), 32'h0);
      u_lst_line_model.st_digit(3);
      u_lst_line_model.ms(70);
      rdf(A_INFO, 32'hF, 32'h3);
      u_lst_line_model.ms(350);
      u_lst_line_model.st(1'b0, 300);
      u_lst_line_model.st(1'b1, 20);
      rdf(A_STAT, 32'h6, 32'h2);
      u_lst_line_model.st(1'b0, 1050);
      rdf(A_STAT, 32'h4, 32'h4);
      u_lst_line_model.st(1'b1, 200);
      rdf(A_INFO, 32'h100, 32'h0);
      u_lst_line_model.st(1'b0, 10);
      $display("station done");
   endtask : t_station
   task automatic t_trunk();
      u_lst_line_model.cur(1'b1);
      u_lst_line_model.ms(45);
      rdf(A_STAT, 32'h20, 32'h0);
      u_lst_line_model.ms(6);
      rdf(A_STAT, 32'h20, 32'h20);
      u_lst_line_model.tr_digit(2);
      u_lst_line_model.ms(80);
      rdf(A_INFO, 32'hF0, 32'h20);
      u_lst_line_model.cur(1'b0);
      $display("trunk done");
   endtask : t_trunk
   // Sent digit: count breaks, time whole digit with pause
   task automatic t_tx();
      int n;
      int el;
      logic prev;
      n = 0;
      el = 0;
      prev = 1'b1;
      wr(A_STAT, 32'hFF);
      wr(A_MASK, 32'h80);
      wr(A_CTRL, 32'h22);
      while (irq !== 1'b1 && el < 30000) begin
         @(posedge aclk);
         el++;
         if (prev && !tr_tx_closed) n++;
         prev = tr_tx_closed;
      end
      chk(n, 2);
      chk(32'(el >= 19900), 32'h1);
      $display("transmit done");
   endtask : t_tx
   task automatic t_disc();
      int n;
      n = 0;
      wr(8'h20, 32'h0032012C);
      wr(A_CTRL, 32'h1);
      u_lst_line_model.far_pulse();
      @(posedge aclk); // Open shows a cycle later
      while (n < 2000 && st_loop_open !== 1'b0) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(n >= 980 && n <= 1003), 32'h1);
      wr(A_CTRL, 32'h0);
      u_lst_line_model.far_pulse();
      repeat (3) @(posedge aclk);
      chk(32'(st_loop_open), 32'h0);
      $display("disconnect done");
   endtask : t_disc
   task automatic t_ring();
      logic [3:0] seen;
      seen = 4'h0;
      wr(8'h24, 32'h00300005);
      u_lst_line_model.ring(8'hFF);
      repeat (30 * TD) begin
         @(posedge aclk);
         seen |= {ring_out == 8'hC0, ring_out == 8'h30, ring_out == 8'h0C, ring_out == 8'h03};
      end
      chk(32'(seen), 32'hF);
      $display("ring done");
   endtask : t_ring
   ////////////////////////////////////////
   // Cut a hang short
   always @(posedge aclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         summarize();
      end
   end
   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_station();
      t_trunk();
      t_tx();
      t_disc();
      t_ring();
      summarize();
   end
endmodule : lst_top_tb_top
bind lst_top lst_properties #(.TICK_DIV(TICK_DIV)) u_lst_properties (.*);
